// >>> hdl/wpba_pkg.sv
// Constants shared by the weighted-priority bandwidth arbiter.
`default_nettype none

package wpba_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int WPBA_NREQ      = 7;
  localparam int WPBA_NRES      = 4;
  localparam int WPBA_CNT_W     = 8;
  localparam int RES_W          = 2;
  localparam int REQ_IDX_W      = 3;
  localparam int PRIO_W         = 4;
  localparam int LVL_W          = 4;

  // ----------------------------------------------------------------------
  // Requester and resource indices
  // ----------------------------------------------------------------------
  localparam int REQ_EXT_DMA    = 0;
  localparam int REQ_INT_DMA    = 1;
  localparam int REQ_BLOCK_COH  = 2;
  localparam int REQ_GLOBAL_COH = 3;
  localparam int REQ_CPU_DIRECT = 4;
  localparam int REQ_DATA_LS    = 5;
  localparam int REQ_PROG_FETCH = 6;
  localparam int RES_L1P        = 0;
  localparam int RES_L1D        = 1;
  localparam int RES_L2         = 2;
  localparam int RES_CFG_BUS    = 3;

  // ----------------------------------------------------------------------
  // Priority encoding
  // ----------------------------------------------------------------------
  // Internal level is the printed level plus one, so -1 maps to zero.
  localparam logic [PRIO_W-1:0] PRIO_LEAST = 4'h8;
  localparam logic [LVL_W-1:0]  LVL_ESC    = 4'h0;
  localparam logic [LVL_W-1:0]  LVL_STEP   = 4'h1;
  localparam logic [LVL_W-1:0]  LVL_LEAST  = 4'h9;
  localparam logic [LVL_W-1:0]  LVL_NONE   = 4'hF;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [WPBA_CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [WPBA_NREQ-1:0]  GNT_RST = 7'h00;

endpackage : wpba_pkg

`default_nettype wire

// >>> hdl/wpba_contention_counter.sv
// Contention counter of one resource.
`default_nettype none

module wpba_contention_counter
  import wpba_pkg::*;
#(
  parameter int CNT_W = WPBA_CNT_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Control
  input  wire logic             contend_i,
  input  wire logic             reload_i,
  input  wire logic [CNT_W-1:0] period_i,
  // Status
  output logic                  expired_o
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // ----------------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------------
  // A blocked escalation holds the count at zero so it retries.
  always_comb begin
    next_count = count;
    if (reload_i) begin
      next_count = (period_i == '0) ? '0 : period_i - 1'b1;
    end else if (contend_i && count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= CNT_RST;
    end else begin
      count <= next_count;
    end
  end

  assign expired_o = contend_i && (count == '0);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_reload_value: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (reload_i && period_i != '0) |=>
      (count == CNT_W'($past(period_i) - 1'b1)))
    else $error("Counter did not reload to period minus one.");

endmodule : wpba_contention_counter

`default_nettype wire

// >>> hdl/wpba_arbiter.sv
// Weighted-priority bandwidth arbiter for the shared core resources.
//
// Operation
// - Nine priority levels 0 to 8; level 0 most urgent, 8 least.
// - Every transfer request carries its own priority level; codes above 8 count as level 8.
// - Among contending requests for one resource, the most urgent wins.
// - Persistent contention lets a losing lower-priority requester win once per n.
// - Escalated level -1 beats level 0; used by expiry and fixed-top.
// - Requesters: both DMA engines, coherency ops, CPU direct, data, fetch.
// - Each resource has its own arbitration: L1P, L1D, L2, config bus.
// - A priority value means the same at every resource arbiter.
`default_nettype none

module wpba_arbiter
  import wpba_pkg::*;
#(
  parameter int NREQ  = WPBA_NREQ,
  parameter int NRES  = WPBA_NRES,
  parameter int CNT_W = WPBA_CNT_W
) (
  // Clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  // Transfer requests
  input  wire logic [NREQ-1:0]                 req_i,
  input  wire logic [NREQ-1:0][RES_W-1:0]      req_res_i,
  input  wire logic [NREQ-1:0][PRIO_W-1:0]     req_prio_i,
  // Software settings
  input  wire logic [NRES-1:0][CNT_W-1:0]      contention_n_i,
  input  wire logic [NRES-1:0]                 fix_top_en_i,
  input  wire logic [NRES-1:0][REQ_IDX_W-1:0]  fix_top_sel_i,
  // Grants
  output logic      [NRES-1:0][NREQ-1:0]       grant_o,
  output logic      [NRES-1:0]                 grant_escalated_o
);

  // ----------------------------------------------------------------------
  // Level mapping
  // ----------------------------------------------------------------------
  // Out-of-range codes fall to the least urgent level rather than
  // outranking legal traffic.
  function automatic logic [LVL_W-1:0] norm_level(
    input logic [PRIO_W-1:0] prio
  );
    if (prio > PRIO_LEAST) begin
      return LVL_LEAST;
    end
    return LVL_W'(prio) + LVL_STEP;
  endfunction : norm_level

  logic [NREQ-1:0][LVL_W-1:0]           lvl;
  logic [NRES-1:0][NREQ-1:0]            hit;
  logic [NRES-1:0][NREQ-1:0]            fixed;
  logic [NRES-1:0][NREQ-1:0][LVL_W-1:0] eff;
  logic [NRES-1:0]                      contend;
  logic [NRES-1:0]                      expired;
  logic [NRES-1:0]                      reload;
  logic [NRES-1:0]                      fix_hit;
  logic [NRES-1:0][REQ_IDX_W-1:0]       esc_pick;
  logic [NRES-1:0][REQ_IDX_W-1:0]       win;
  logic [NRES-1:0]                      win_valid;
  logic [NRES-1:0]                      esc_taken;
  logic [NRES-1:0][NREQ-1:0]            next_grant;
  logic [NRES-1:0]                      next_grant_escalated;

  // ----------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------
  always_comb begin
    logic [LVL_W-1:0] worst;
    int               nhit;
    worst    = LVL_ESC;
    nhit     = 0;
    hit      = '0;
    fixed    = '0;
    contend  = '0;
    fix_hit  = '0;
    esc_pick = '0;
    for (int q = 0; q < NREQ; q++) begin
      lvl[q] = norm_level(req_prio_i[q]);
    end
    for (int r = 0; r < NRES; r++) begin
      nhit  = 0;
      worst = LVL_ESC;
      for (int q = 0; q < NREQ; q++) begin
        hit[r][q]   = req_i[q] && (req_res_i[q] == RES_W'(r));
        fixed[r][q] = fix_top_en_i[r] &&
                      (fix_top_sel_i[r] == REQ_IDX_W'(q));
        if (hit[r][q]) begin
          nhit = nhit + 1;
          fix_hit[r] = fix_hit[r] || fixed[r][q];
          // Starved pick is the least urgent, latest on a tie, so it is
          // never the requester that would have won anyway.
          if (lvl[q] >= worst) begin
            worst       = lvl[q];
            esc_pick[r] = REQ_IDX_W'(q);
          end
        end
      end
      contend[r] = (nhit > 1);
    end
  end

  // The pick reads the counters, which read contend above; two separate
  // processes keep that path free of a false combinational loop.
  always_comb begin
    logic [LVL_W-1:0] best;
    best                 = LVL_NONE;
    eff                  = '0;
    win                  = '0;
    win_valid            = '0;
    esc_taken            = '0;
    reload               = '0;
    next_grant           = '0;
    next_grant_escalated = '0;
    for (int r = 0; r < NRES; r++) begin
      best = LVL_NONE;
      for (int q = 0; q < NREQ; q++) begin
        if (fixed[r][q] ||
            (expired[r] && esc_pick[r] == REQ_IDX_W'(q))) begin
          eff[r][q] = LVL_ESC;
        end else begin
          eff[r][q] = lvl[q];
        end
        if (hit[r][q] && eff[r][q] < best) begin
          best         = eff[r][q];
          win[r]       = REQ_IDX_W'(q);
          win_valid[r] = 1'b1;
        end
      end
      esc_taken[r] = expired[r] && (win[r] == esc_pick[r]);
      reload[r]    = !contend[r] || esc_taken[r];
      for (int q = 0; q < NREQ; q++) begin
        next_grant[r][q] = win_valid[r] && (win[r] == REQ_IDX_W'(q));
      end
      next_grant_escalated[r] = esc_taken[r];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      grant_o           <= {NRES{GNT_RST}};
      grant_escalated_o <= '0;
    end else begin
      grant_o           <= next_grant;
      grant_escalated_o <= next_grant_escalated;
    end
  end

  // ----------------------------------------------------------------------
  // Contention counters
  // ----------------------------------------------------------------------
  for (genvar r = 0; r < NRES; r++) begin : g_cnt
    wpba_contention_counter #(
      .CNT_W     (CNT_W)
    ) u_cnt (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .contend_i (contend[r]),
      .reload_i  (reload[r]),
      .period_i  (contention_n_i[r]),
      .expired_o (expired[r])
    );
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [NRES-1:0][LVL_W-1:0] min_lvl;
  logic [NRES-1:0][NREQ-1:0]  lower_tie;
  logic [NRES-1:0][CNT_W-1:0] run;

  always_comb begin
    min_lvl   = {NRES{LVL_NONE}};
    lower_tie = '0;
    for (int r = 0; r < NRES; r++) begin
      for (int q = 0; q < NREQ; q++) begin
        if (hit[r][q] && lvl[q] < min_lvl[r]) begin
          min_lvl[r] = lvl[q];
        end
        for (int p = 0; p < q; p++) begin
          if (hit[r][p] && eff[r][p] == eff[r][q]) begin
            lower_tie[r][q] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run <= '0;
    end else begin
      for (int r = 0; r < NRES; r++) begin
        if (reload[r]) begin
          run[r] <= '0;
        end else if (run[r] != '1) begin
          run[r] <= run[r] + 1'b1;
        end
      end
    end
  end

  for (genvar r = 0; r < NRES; r++) begin : g_chk
    a_grant_onehot: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      $onehot0(grant_o[r]))
      else $error("More than one grant on a resource.");

    a_no_idle_loss: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (|hit[r]) |=> (|grant_o[r]))
      else $error("Pending request got no grant.");

    a_expiry_period: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (contend[r] && contention_n_i[r] != '0 &&
       run[r] == CNT_W'(contention_n_i[r] - 1'b1)) |-> expired[r])
      else $error("Counter did not expire after n contended cycles.");

    a_esc_wins: assert property (
      @(posedge clk_i) disable iff (!reset_n_i)
      (expired[r] && !fix_hit[r]) |=> grant_escalated_o[r])
      else $error("Escalated transfer was not granted.");

    for (genvar q = 0; q < NREQ; q++) begin : g_req
      a_grant_had_req: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        grant_o[r][q] |-> $past(hit[r][q]))
        else $error("Grant without a matching request.");

      a_winner_urgent: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (grant_o[r][q] && !grant_escalated_o[r] && !$past(fix_hit[r]))
          |-> ($past(lvl[q]) == $past(min_lvl[r])))
        else $error("Grant went to a less urgent transfer.");

      a_tie_order: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        grant_o[r][q] |-> !$past(lower_tie[r][q]))
        else $error("Tie not resolved by requester order.");

      a_fixed_top: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (hit[r][q] && fixed[r][q] && !expired[r]) |=> grant_o[r][q])
        else $error("Fixed top requester was not granted.");

      a_level_range: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (lvl[q] >= LVL_STEP) && (lvl[q] <= LVL_LEAST))
        else $error("Transfer level outside the nine levels.");
    end
  end

endmodule : wpba_arbiter

`default_nettype wire

// >>> dv/wpba_requester_model.sv
// Requester side model: presents transfers and, unless hold is set, drops each one it wins.
`default_nettype none

module wpba_requester_model
  import wpba_pkg::*;
(
  // Clock
  input  wire logic                    clk_i,
  // Commands from the bench
  input  wire logic                    load_i,
  input  wire logic                    hold_i,
  input  wire logic [6:0]              new_req_i,
  input  wire logic [6:0][RES_W-1:0]   new_res_i,
  input  wire logic [6:0][PRIO_W-1:0]  new_prio_i,
  // Grants seen
  input  wire logic [3:0][6:0]         grant_i,
  // Requests to the arbiter
  output logic      [6:0]              req_o,
  output logic      [6:0][RES_W-1:0]   res_o,
  output logic      [6:0][PRIO_W-1:0]  prio_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------
  // Request drive
  // --------------------------------------------------------------------
  // Changes land on the falling edge, clear of the arbiter's sampling.
  // Hold keeps a won request up, which is how contention is prolonged.
  always @(negedge clk_i) begin
    if (load_i) begin
      req_o <= new_req_i;
      res_o <= new_res_i;
      prio_o <= new_prio_i;
    end else if (!hold_i) begin
      for (int q = 0; q < 7; q++) begin
        if (grant_i[res_o[q]][q]) begin
          req_o[q] <= 1'b0;
        end
      end
    end
  end

endmodule : wpba_requester_model

`default_nettype wire

// >>> dv/wpba_arbiter_tb.sv
// Self-checking bench for the weighted-priority bandwidth arbiter.
`default_nettype none

module wpba_arbiter_tb
  import wpba_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int r; int a; int pa; int b; int pb; int w;} wpba_row_s;

  logic            clk;
  logic            reset_n;
  logic            ld;
  logic            hold;
  logic [6:0]      n_req;
  logic [6:0][1:0] n_res;
  logic [6:0][3:0] n_prio;
  logic [6:0]      req;
  logic [6:0][1:0] res;
  logic [6:0][3:0] prio;
  logic [3:0][7:0] cn;
  logic [3:0]      fx_en;
  logic [3:0][2:0] fx_sel;
  logic [3:0][6:0] gnt;
  logic [3:0]      esc;
  int              bad_count;
  int              n_compared;
  int              cyc;
  int              w;
  int              nv [3] = '{1, 2, 4};
  wpba_row_s       rows [6] = '{'{1, 5, 3, 0, 5, 5}, '{0, 6, 0, 2, 8, 6},
    '{2, 1, 4, 3, 4, 1}, '{3, 4, 8, 0, 15, 0}, '{2, 0, 7, 6, 2, 6},
    '{3, 2, 1, 5, 0, 5}};

  wpba_arbiter wpba_arbiter_inst (
    .clk_i(clk), .reset_n_i(reset_n), .req_i(req), .req_res_i(res),
    .req_prio_i(prio), .contention_n_i(cn), .fix_top_en_i(fx_en),
    .fix_top_sel_i(fx_sel), .grant_o(gnt), .grant_escalated_o(esc));

  wpba_requester_model wpba_requester_model_inst (
    .clk_i(clk), .load_i(ld), .hold_i(hold), .new_req_i(n_req),
    .new_res_i(n_res), .new_prio_i(n_prio), .grant_i(gnt),
    .req_o(req), .res_o(res), .prio_o(prio));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  always #10 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [27:0] s, e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  function automatic logic [27:0] gv(input int r, input int q);
    return 28'h0000001 << (r * 7 + q);
  endfunction : gv

  // Commands reach the model on the rising edge; it drives the falling one.
  task automatic put(input logic [6:0] rq, input logic [6:0][1:0] rs,
                     input logic [6:0][3:0] pr, input logic h);
    @(posedge clk);
    ld <= 1'b1;
    hold <= h;
    n_req <= rq;
    n_res <= rs;
    n_prio <= pr;
    @(posedge clk);
    ld <= 1'b0;
  endtask : put

  task automatic pair(input int r, a, pa, b, pb, input logic h);
    logic [6:0]      rq;
    logic [6:0][1:0] rs;
    logic [6:0][3:0] pr;
    rq = '0;
    rs = '0;
    pr = '0;
    rq[a] = 1'b1;
    rq[b] = 1'b1;
    rs[a] = r[1:0];
    rs[b] = r[1:0];
    pr[a] = pa[3:0];
    pr[b] = pb[3:0];
    put(rq, rs, pr, h);
    @(negedge clk);
  endtask : pair

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    // Load stays up until the first put, so the model starts idle.
    ld = 1'b1;
    hold = 1'b0;
    n_req = '0;
    n_res = '0;
    n_prio = '0;
    cn = {4{8'hFF}};
    fx_en = '0;
    fx_sel = '0;
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (8) @(negedge clk);
    chk("reset grant", gnt, '0);
    reset_n = 1'b1;
    put('0, '0, '0, 1'b0);
    foreach (rows[i]) begin
      pair(rows[i].r, rows[i].a, rows[i].pa, rows[i].b, rows[i].pb, 1'b0);
      chk("winner", gnt, gv(rows[i].r, rows[i].w));
      chk("no escal", {24'h000000, esc}, '0);
      @(negedge clk);
      w = rows[i].a + rows[i].b - rows[i].w;
      chk("loser", gnt, gv(rows[i].r, w));
      @(negedge clk);
      chk("idle", gnt, '0);
    end
    $display("done rows");
    // Slow requester 0 must break through once every n contended cycles.
    foreach (nv[k]) begin
      @(negedge clk);
      cn = {4{nv[k][7:0]}};
      put('0, '0, '0, 1'b0);
      pair(1, 5, 3, 0, 5, 1'b1);
      for (int i = 0; i < 8; i++) begin
        w = (i % nv[k] == nv[k] - 1) ? 0 : 5;
        chk("starve grant", gnt, gv(1, w));
        chk("starve flag", {24'h000000, esc}, (w == 0) ? 28'h2 : 28'h0);
        @(negedge clk);
      end
    end
    cn = {4{8'hFF}};
    put('0, '0, '0, 1'b0);
    $display("done starvation");
    @(negedge clk);
    fx_en = 4'h4;
    fx_sel[2] = 3'h6;
    pair(2, 6, 8, 1, 0, 1'b0);
    chk("fixed top", gnt, gv(2, 6));
    chk("fixed flag", {24'h000000, esc}, '0);
    @(negedge clk);
    chk("after fixed", gnt, gv(2, 1));
    fx_en = '0;
    put(7'h1F, {2'h0, 2'h0, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0},
        {4'h8, 4'h8, 4'h0, 4'h8, 4'h8, 4'h8, 4'h8}, 1'b0);
    @(negedge clk);
    chk("per resource", gnt, gv(0, 0) | gv(1, 1) | gv(2, 4) | gv(3, 3));
    @(negedge clk);
    chk("l2 remains", gnt, gv(2, 2));
    $display("done fixed and resources");
    // A counter left expired by reset escalates the first contended cycle.
    pair(1, 5, 3, 0, 5, 1'b1);
    reset_n = 1'b0;
    #1;
    chk("async clear", gnt, '0);
    repeat (2) @(negedge clk);
    chk("held clear", gnt, '0);
    reset_n = 1'b1;
    @(negedge clk);
    chk("first escal", gnt, gv(1, 0));
    chk("first flag", {24'h000000, esc}, 28'h2);
    @(negedge clk);
    chk("reloaded", gnt, gv(1, 5));
    $display("done reset");
    final_report();
  end

endmodule : wpba_arbiter_tb

`default_nettype wire
